// >>> design/rcs_consts.svh
`ifndef RCS_CONSTS_SVH
`define RCS_CONSTS_SVH

// ****************************************
// timing
// ****************************************
`define RCS_CLK_PERIOD_NS 50
`define RCS_PCLK_LOSS_NS 400
// longest allowed silence, rounded down to whole cycles
`define RCS_LOSS_CYC (`RCS_PCLK_LOSS_NS / `RCS_CLK_PERIOD_NS)
`define RCS_GAP_CYC 3'd2
`define RCS_STRAP_WAIT 2'd2

// ****************************************
// register indices (byte address = index * 4)
// ****************************************
`define RCS_IDX_CLK_CTRL 8'h03
`define RCS_IDX_OSC_RATE 8'h14
`define RCS_IDX_STATUS 8'h20
`define RCS_IDX_GPO_CTRL 8'h21
`define RCS_IDX_VID_CTRL 8'h22

// ****************************************
// fields and reset values
// ****************************************
`define RCS_PCLK_HOLD_BIT 1
`define RCS_RATE_HI 2
`define RCS_RATE_LO 1
`define RCS_CLK_CTRL_RST 8'h00
`define RCS_OSC_RATE_RST 8'h00
`define RCS_GPO_CTRL_RST 8'h00
`define RCS_VID_CTRL_RST 8'h00
`define RCS_RATE_FAST 2'b01
`define RCS_RATE_RSVD 2'b11
`define RCS_HALF_SLOW 3'd4
`define RCS_HALF_FAST 3'd2

// ****************************************
// mode strap ratio, thousandths
// ****************************************
`define RCS_PIX_MIN 10'd750
`define RCS_PIX_MAX 10'd1000
`define RCS_OSC_MIN 10'd292
`define RCS_OSC_MAX 10'd339

// ****************************************
// self-test pattern
// ****************************************
`define RCS_LFSR_SEED 14'h0001

`endif

// >>> design/rcs_pkg.sv
package rcs_pkg;
    typedef enum logic [1:0] {
        RCS_RUN_INT = 2'b00,
        RCS_GAP_PCLK = 2'b01,
        RCS_RUN_PCLK = 2'b10,
        RCS_GAP_INT = 2'b11
    } rcs_src_t;
    typedef logic [13:0] rcs_word_t;
endpackage : rcs_pkg

// >>> design/rcs_clk_watch.sv
`include "rcs_consts.svh"

// syncs one external clock pin, flags rising edges and presence
module rcs_clk_watch (
    input wire logic clk_sys, // system clock
    input wire logic rstn, // async reset, active low
    input wire logic pin, // external clock pin
    output logic level, // synchronised level
    output logic rise, // one-cycle pulse per rising edge
    output logic present // level, edges seen recently
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic [3:0] idle_q;
    logic [3:0] idle_d;

    // ****************************************
    // synchroniser; only s2 reads s1
    // ****************************************
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign level = s2_q;
    assign rise = s2_q & ~s3_q;

    // silence counter; sampled at clk_sys, so fast clocks alias but still toggle
    assign idle_d = (s2_q != s3_q) ? 4'd0 :
                    (idle_q == 4'(`RCS_LOSS_CYC)) ? idle_q : idle_q + 4'd1;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            idle_q <= 4'(`RCS_LOSS_CYC);
        end else begin
            idle_q <= idle_d;
        end
    end

    assign present = (idle_q != 4'(`RCS_LOSS_CYC));
endmodule : rcs_clk_watch

// >>> design/rcs_ref_clock.sv
// The Avalon-MM register port was left to the implementer.
`include "rcs_consts.svh"

module rcs_ref_clock (
    input wire logic clk_sys, // 20 MHz system clock
    input wire logic rstn, // async reset, active low
    input wire logic [7:0] avs_address, // word index
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // byte lanes
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall
    input wire logic [9:0] mode_strap_ratio, // digitised strap ratio x1000
    input wire logic pclk_pin, // imager pixel clock
    input wire logic [3:0] gpo_in, // pad input of the general pins
    output logic [3:0] gpo_out, // general pin drive
    output logic [3:0] gpo_oe, // general pin enable
    input wire logic [3:0] remote_gpio, // remote pin values, back channel
    input wire logic bc_self_test, // self-test commanded, back channel
    input wire logic bc_rate_load, // pulse: rate word valid
    input wire logic [1:0] bc_rate, // rate word from far end
    input wire rcs_pkg::rcs_word_t video_in, // imager data and sync
    output rcs_pkg::rcs_word_t link_data, // word to serial framer
    output logic link_on_int_osc, // link clocked by internal osc
    output logic core_clk // serializer core clock
);
    import rcs_pkg::*;

    // ****************************************
    // declarations
    // ****************************************
    logic [9:0] strap_s1_q, strap_s2_q;
    logic [1:0] strap_cnt_q;
    logic strap_done_q, osc_mode_q, strap_pix_win, strap_osc_win;
    logic [7:0] clk_ctrl_q, osc_rate_q, gpo_ctrl_q, vid_ctrl_q, status_w;
    logic ack_q, req, take, wr_take, sel_clk, sel_rate, sel_gpo, sel_vid;
    logic [31:0] rdata_q, rdata_d;
    logic osc_rise, osc_present, pclk_level, pclk_rise, pclk_present;
    logic half_q, int_osc_q, want_pclk, core_q, st_fault;
    logic [1:0] rate;
    logic [2:0] int_cnt_q, int_half, gap_q;
    rcs_src_t src_q, src_d;
    rcs_word_t lfsr_q, link_q, vid_masked;
    logic [3:0] gpo_q, gpo_oe_q;

    // ****************************************
    // pin watchers
    // ****************************************
    rcs_clk_watch u_osc (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .pin(gpo_in[3]),
        .level(),
        .rise(osc_rise),
        .present(osc_present)
    );

    rcs_clk_watch u_pclk (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .pin(pclk_pin),
        .level(pclk_level),
        .rise(pclk_rise),
        .present(pclk_present)
    );

    // ****************************************
    // mode strap, caught after reset release
    // ****************************************
    assign strap_pix_win = (strap_s2_q >= `RCS_PIX_MIN) && (strap_s2_q <= `RCS_PIX_MAX);
    assign strap_osc_win = (strap_s2_q >= `RCS_OSC_MIN) && (strap_s2_q <= `RCS_OSC_MAX);

    // out-of-window ratios fall back to pixel clock mode
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            strap_s1_q <= 10'h000;
            strap_s2_q <= 10'h000;
            strap_cnt_q <= 2'h0;
            strap_done_q <= 1'b0;
            osc_mode_q <= 1'b0;
        end else begin
            strap_s1_q <= mode_strap_ratio;
            strap_s2_q <= strap_s1_q;
            if (!strap_done_q) begin
                strap_cnt_q <= strap_cnt_q + 2'h1;
                if (strap_cnt_q == `RCS_STRAP_WAIT) begin
                    strap_done_q <= 1'b1;
                    osc_mode_q <= strap_osc_win & ~strap_pix_win;
                end
            end
        end
    end

    // ****************************************
    // register bus, one wait cycle per access
    // ****************************************
    assign req = avs_read | avs_write;
    assign take = req & ~ack_q;
    assign wr_take = avs_write & ack_q & avs_byteenable[0]; // lands as waitrequest drops
    assign avs_waitrequest = req & ~ack_q;
    assign sel_clk = (avs_address == `RCS_IDX_CLK_CTRL);
    assign sel_rate = (avs_address == `RCS_IDX_OSC_RATE);
    assign sel_gpo = (avs_address == `RCS_IDX_GPO_CTRL);
    assign sel_vid = (avs_address == `RCS_IDX_VID_CTRL);
    assign status_w = {1'b0, rate, st_fault, bc_self_test,
                       (src_q == RCS_RUN_PCLK), pclk_present, osc_mode_q};
    assign rdata_d = sel_clk ? {24'h0, clk_ctrl_q} :
                     sel_rate ? {24'h0, osc_rate_q} :
                     (avs_address == `RCS_IDX_STATUS) ? {24'h0, status_w} :
                     sel_gpo ? {24'h0, gpo_ctrl_q} :
                     sel_vid ? {24'h0, vid_ctrl_q} : 32'h0;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0;
        end else begin
            ack_q <= take;
            if (avs_read & take) begin
                rdata_q <= rdata_d;
            end
        end
    end

    assign avs_readdata = rdata_q;

    // ****************************************
    // control registers
    // ****************************************
    // the far end owns the rate during self-test; local writes to it drop
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            clk_ctrl_q <= `RCS_CLK_CTRL_RST;
            osc_rate_q <= `RCS_OSC_RATE_RST;
            gpo_ctrl_q <= `RCS_GPO_CTRL_RST;
            vid_ctrl_q <= `RCS_VID_CTRL_RST;
        end else begin
            if (wr_take && sel_clk) begin
                clk_ctrl_q <= avs_writedata[7:0];
            end
            if (wr_take && sel_gpo) begin
                gpo_ctrl_q <= avs_writedata[7:0];
            end
            if (wr_take && sel_vid) begin
                vid_ctrl_q <= avs_writedata[7:0];
            end
            if (bc_self_test) begin
                if (bc_rate_load) begin
                    osc_rate_q[`RCS_RATE_HI:`RCS_RATE_LO] <= bc_rate;
                end
            end else if (wr_take && sel_rate) begin
                osc_rate_q <= avs_writedata[7:0];
            end
        end
    end

    assign rate = osc_rate_q[`RCS_RATE_HI:`RCS_RATE_LO];

    // ****************************************
    // internal oscillator model
    // ****************************************
    // codes 00 and 10 give the slow rate, 01 the fast one
    assign int_half = (rate == `RCS_RATE_FAST) ? `RCS_HALF_FAST : `RCS_HALF_SLOW;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            int_cnt_q <= 3'h0;
            int_osc_q <= 1'b0;
        end else if (rate == `RCS_RATE_RSVD) begin
            int_cnt_q <= 3'h0;
            int_osc_q <= 1'b0;
        end else if (int_cnt_q + 3'h1 >= int_half) begin
            int_cnt_q <= 3'h0;
            int_osc_q <= ~int_osc_q;
        end else begin
            int_cnt_q <= int_cnt_q + 3'h1;
        end
    end

    // ****************************************
    // oscillator halving for the imager
    // ****************************************
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            half_q <= 1'b0;
        end else if (osc_mode_q && osc_rise) begin
            half_q <= ~half_q;
        end
    end

    // ****************************************
    // core clock source selection
    // ****************************************
    assign want_pclk = pclk_present & ~clk_ctrl_q[`RCS_PCLK_HOLD_BIT];

    // a source is left or taken while its level is low, with a dead gap; a lost pixel clock is left at once at any level
    always_comb begin
        src_d = src_q;
        unique case (src_q)
            RCS_RUN_INT: begin
                if (want_pclk && pclk_rise && !int_osc_q) begin
                    src_d = RCS_GAP_PCLK;
                end
            end
            RCS_GAP_PCLK: begin
                if (!want_pclk) begin
                    src_d = RCS_GAP_INT;
                end else if (gap_q == `RCS_GAP_CYC && !pclk_level) begin
                    src_d = RCS_RUN_PCLK;
                end
            end
            RCS_RUN_PCLK: begin
                if (!want_pclk && !pclk_level) begin
                    src_d = RCS_GAP_INT;
                end else if (!pclk_present) begin
                    src_d = RCS_GAP_INT;
                end
            end
            RCS_GAP_INT: begin
                if (gap_q == `RCS_GAP_CYC && !int_osc_q) begin
                    src_d = RCS_RUN_INT;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            src_q <= RCS_RUN_INT;
            gap_q <= 3'h0;
            core_q <= 1'b0;
        end else begin
            src_q <= src_d;
            gap_q <= (src_d != src_q) ? 3'h0 :
                     (gap_q == `RCS_GAP_CYC) ? gap_q : gap_q + 3'h1;
            core_q <= (src_d == RCS_RUN_INT) ? int_osc_q :
                      (src_d == RCS_RUN_PCLK) ? pclk_level : 1'b0;
        end
    end

    assign core_clk = core_q;
    assign link_on_int_osc = (src_q != RCS_RUN_PCLK);

    // ****************************************
    // link word: video or self-test pattern
    // ****************************************
    // both clocks must run for oscillator-mode self-test
    assign st_fault = bc_self_test & osc_mode_q & ~(osc_present & pclk_present);
    // 10-bit mode keeps two sync bits, upper data bits forced low
    assign vid_masked = vid_ctrl_q[0] ? video_in : {video_in[13:12], 2'b00, video_in[9:0]};

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            lfsr_q <= `RCS_LFSR_SEED;
            link_q <= 14'h0000;
        end else begin
            if (bc_self_test) begin
                lfsr_q <= {lfsr_q[12:0], lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[11] ^ lfsr_q[1]};
                link_q <= lfsr_q;
            end else begin
                lfsr_q <= `RCS_LFSR_SEED;
                link_q <= vid_masked;
            end
        end
    end

    assign link_data = link_q;

    // ****************************************
    // general pins
    // ****************************************
    // gpo_ctrl: bits 3:0 local value, bits 7:4 forward remote value
    generate
        for (genvar i = 0; i < 4; i++) begin : g_gpo
            logic pin_val;
            logic pin_en;
            if (i == 3) begin : g_p3
                assign pin_en = ~osc_mode_q;
                assign pin_val = gpo_ctrl_q[4 + i] ? remote_gpio[i] : gpo_ctrl_q[i];
            end else if (i == 2) begin : g_p2
                assign pin_en = 1'b1;
                assign pin_val = osc_mode_q ? half_q :
                                 gpo_ctrl_q[4 + i] ? remote_gpio[i] : gpo_ctrl_q[i];
            end else begin : g_pn
                assign pin_en = 1'b1;
                assign pin_val = gpo_ctrl_q[4 + i] ? remote_gpio[i] : gpo_ctrl_q[i];
            end
            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    gpo_q[i] <= 1'b0;
                    gpo_oe_q[i] <= 1'b0;
                end else begin
                    gpo_q[i] <= pin_en & pin_val;
                    gpo_oe_q[i] <= pin_en & strap_done_q;
                end
            end
        end
    endgenerate

    assign gpo_out = gpo_q;
    assign gpo_oe = gpo_oe_q;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence gap_pclk_s;
        src_q == RCS_GAP_PCLK;
    endsequence

    sequence run_pclk_s;
        src_q == RCS_RUN_PCLK;
    endsequence

    half_clock_a: assert property (osc_mode_q && osc_rise |=> half_q != $past(half_q))
        else $error("halved clock did not toggle on oscillator edge");
    pin3_input_a: assert property (osc_mode_q |-> !gpo_oe[3])
        else $error("pin 3 driven in oscillator mode");
    pin2_half_a: assert property (osc_mode_q && strap_done_q |=> gpo_out[2] == $past(half_q))
        else $error("pin 2 not carrying halved clock");
    pclk_take_a: assert property (gap_pclk_s ##1 run_pclk_s |-> !$past(clk_ctrl_q[`RCS_PCLK_HOLD_BIT]))
        else $error("switched to pixel clock while hold bit set");
    pclk_loss_a: assert property (run_pclk_s and !pclk_present |=> src_q == RCS_GAP_INT)
        else $error("pixel clock lost but source kept");
    hold_bit_a: assert property (src_q == RCS_RUN_INT && clk_ctrl_q[`RCS_PCLK_HOLD_BIT]
        |=> src_q == RCS_RUN_INT)
        else $error("left internal oscillator with hold bit set");
    gap_low_a: assert property ((src_q inside {RCS_GAP_PCLK, RCS_GAP_INT}) [*2] |-> !core_clk)
        else $error("core clock high during switch gap");
    rate_lock_a: assert property (bc_self_test && !bc_rate_load |=> $stable(rate))
        else $error("rate changed in self-test without back channel load");
    rsvd_stop_a: assert property ((rate == `RCS_RATE_RSVD) [*3] |-> !int_osc_q)
        else $error("internal oscillator runs on reserved code");
    pattern_a: assert property (bc_self_test |=> link_data == $past(lfsr_q))
        else $error("self-test pattern not on link");
    int_link_a: assert property (!pclk_present && src_q != RCS_GAP_PCLK |=> link_on_int_osc)
        else $error("link not on internal oscillator without pixel clock");
    all_pins_a: assert property (!osc_mode_q && strap_done_q |=> gpo_oe == 4'hf)
        else $error("general pins not all driven in pixel clock mode");
endmodule : rcs_ref_clock

// >>> bench/rcs_far_end_model.sv
// imager and far-end back channel seen from the serializer pins
module rcs_far_end_model (
    input wire logic clk_sys, // system clock
    input wire logic rstn, // reset, active low
    input wire logic pclk_on, // imager pixel clock running
    input wire logic st_en, // far end test enable pin
    input wire logic [1:0] st_pins, // far end clock select pins
    output logic osc_clk, // oscillator toward serializer
    output logic pclk_pin, // imager pixel clock
    output logic bc_self_test, // back channel test command
    output logic bc_rate_load, // back channel rate strobe
    output logic [1:0] bc_rate, // back channel rate code
    input wire logic [13:0] link_data, // word from serializer
    output logic st_pass, // far end pass indicator
    output logic [7:0] st_err_cnt // far end error count
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] cnt_q;
    logic run_q;
    logic [13:0] last_q;
    // pixel clock at twice the oscillator; stands low while off
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= 3'h0;
            pclk_pin <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 3'h1;
            pclk_pin <= pclk_on & cnt_q[1];
        end
    end
    assign osc_clk = cnt_q[2];
    // test is set up here only; rate code sent once as the test opens
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            bc_self_test <= 1'b0;
            bc_rate_load <= 1'b0;
            bc_rate <= 2'h0;
        end else begin
            bc_self_test <= st_en;
            bc_rate_load <= st_en & ~bc_self_test;
            // stale code inverted so nobody may rely on it
            bc_rate <= (st_en & ~bc_self_test) ? st_pins : ~bc_rate;
        end
    end
    // a repeated word is a bad frame; one sample cycle stands for a quarter of a pixel clock
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            run_q <= 1'b0;
            last_q <= 14'h0000;
            st_pass <= 1'b0;
            st_err_cnt <= 8'h00;
        end else begin
            run_q <= bc_self_test;
            last_q <= link_data;
            if (st_en & ~bc_self_test) begin
                st_err_cnt <= 8'h00;
            end else if (run_q & bc_self_test & (link_data == last_q)) begin
                st_err_cnt <= st_err_cnt + 8'h01;
            end
            st_pass <= (run_q & bc_self_test) ? (link_data != last_q) :
                       (run_q & ~bc_self_test) ? (st_err_cnt == 8'h00) : 1'b0;
        end
    end
endmodule : rcs_far_end_model

// >>> bench/ser_ref_clock_select_and_link_self_test_test.sv
module ser_ref_clock_select_and_link_self_test_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys, rstn, avs_read, avs_write, avs_waitrequest, pclk_on, st_en, prev_g;
    logic bc_self_test, bc_rate_load, link_on_int_osc, core_clk, osc_clk, pclk_pin, st_pass;
    logic [7:0] avs_address, st_err_cnt;
    logic [31:0] avs_writedata, avs_readdata, d;
    logic [9:0] mode_strap_ratio;
    logic [3:0] gpo_out, gpo_oe, remote_gpio;
    logic [1:0] bc_rate, st_pins;
    rcs_pkg::rcs_word_t video_in, link_data, prev_w;
    wire logic [3:0] gpo_in = {osc_clk, 3'b000};
    int num_errors, num_checks, i, hp, n_out;
    logic [9:0] ratios [8] = '{10'd340, 10'd750, 10'd1000, 10'd500, 10'd291, 10'd292, 10'd339, 10'd300};
    logic exp_osc [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    int hps [4] = '{4, 2, 4, 30};

    rcs_ref_clock DUT (.clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'h1), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .mode_strap_ratio(mode_strap_ratio), .pclk_pin(pclk_pin), .gpo_in(gpo_in),
        .gpo_out(gpo_out), .gpo_oe(gpo_oe), .remote_gpio(remote_gpio),
        .bc_self_test(bc_self_test), .bc_rate_load(bc_rate_load), .bc_rate(bc_rate),
        .video_in(video_in), .link_data(link_data), .link_on_int_osc(link_on_int_osc),
        .core_clk(core_clk));
    rcs_far_end_model far (.clk_sys(clk_sys), .rstn(rstn), .pclk_on(pclk_on), .st_en(st_en),
        .st_pins(st_pins), .osc_clk(osc_clk), .pclk_pin(pclk_pin),
        .bc_self_test(bc_self_test), .bc_rate_load(bc_rate_load), .bc_rate(bc_rate),
        .link_data(link_data), .st_pass(st_pass), .st_err_cnt(st_err_cnt));

    // 20 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %h", $time, msg, got);
        end
    endtask : check

    task automatic expire(input string msg);
        check(0, 1, msg);
        complete_run();
    endtask : expire

    // one bus cycle; request held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address <= idx;
        avs_writedata <= {24'h0, wd};
        avs_write <= wr;
        avs_read <= ~wr;
        @(negedge clk_sys);
        while (avs_waitrequest !== 1'b0) begin
            n++;
            if (n > 20) expire("bus stall");
            @(negedge clk_sys);
        end
        @(posedge clk_sys);
        d = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input string msg);
        bus(1'b0, idx, 8'h00);
        check(d, exp, msg);
    endtask : rd_chk

    task automatic do_reset(input logic [9:0] ratio);
        @(posedge clk_sys);
        rstn <= 1'b0;
        mode_strap_ratio <= ratio;
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (6) @(posedge clk_sys);
    endtask : do_reset

    // bounded count of cycles between two core clock toggles, 30 = none
    task automatic half_period;
        logic v;
        @(negedge clk_sys);
        v = core_clk;
        for (hp = 0; hp < 30 && core_clk === v; hp++) @(negedge clk_sys);
        v = core_clk;
        for (hp = 0; hp < 30 && core_clk === v; hp++) @(negedge clk_sys);
    endtask : half_period

    task automatic wait_oni(input logic exp);
        for (hp = 0; link_on_int_osc !== exp; hp++) begin
            if (hp > 40) expire("clock switch late");
            @(negedge clk_sys);
        end
    endtask : wait_oni

    // tests run in order; the register, strap and pixel-pin tests reset first, the others reuse the state left by the last
    initial begin
        {rstn, avs_read, avs_write, pclk_on, st_en} = 5'h0;
        {avs_address, avs_writedata, remote_gpio, st_pins} = '0;
        mode_strap_ratio = 10'd900;
        video_in = 14'h2155;
        do_reset(10'd900);
        rd_chk(8'h03, 32'h0, "clock control reset");
        rd_chk(8'h14, 32'h0, "rate reset");
        rd_chk(8'h21, 32'h0, "pin control reset");
        rd_chk(8'h22, 32'h0, "video control reset");
        rd_chk(8'h40, 32'h0, "unmapped read");
        bus(1'b1, 8'h20, 8'hff);
        rd_chk(8'h20, 32'h0, "status in pixel mode");
        $display("test registers done");
        for (i = 0; i < 8; i++) begin
            do_reset(ratios[i]);
            bus(1'b0, 8'h20, 8'h00);
            check(d[0], exp_osc[i], "strap decode");
            if (exp_osc[i]) check(gpo_oe[3:2], 2'b01, "oscillator pins");
        end
        $display("test strap done");
        // oscillator mode: pins 2 and 3 belong to the clock path
        bus(1'b1, 8'h21, 8'hf0);
        @(posedge clk_sys);
        remote_gpio <= 4'hf;
        n_out = 0;
        repeat (64) begin
            @(negedge clk_sys);
            if (gpo_out[2] === 1'b1 && prev_g === 1'b0) n_out++;
            prev_g = gpo_out[2];
        end
        check(n_out >= 3 && n_out <= 5, 1, "halved clock rate");
        check(gpo_out[1:0], 2'b11, "remote values on pins 0 1");
        check(gpo_out[3], 1'b0, "remote value kept off pin 3");
        check(gpo_oe[3], 1'b0, "oscillator input pin");
        $display("test oscillator mode done");
        do_reset(10'd900);
        bus(1'b1, 8'h21, 8'hf0);
        @(posedge clk_sys);
        remote_gpio <= 4'ha;
        repeat (4) @(negedge clk_sys);
        check({gpo_oe, gpo_out}, 8'hfa, "remote on four pins");
        bus(1'b1, 8'h21, 8'h05);
        repeat (4) @(negedge clk_sys);
        check(gpo_out, 4'h5, "local on four pins");
        $display("test pixel mode pins done");
        for (i = 0; i < 4; i++) begin
            bus(1'b1, 8'h14, 8'(i << 1));
            rd_chk(8'h14, 32'(i << 1), "rate readback");
            half_period();
            check(hp, hps[i], "internal rate");
        end
        check(link_on_int_osc, 1'b1, "internal without pixel clock");
        $display("test rate done");
        bus(1'b1, 8'h14, 8'h00);
        bus(1'b1, 8'h03, 8'h02);
        @(posedge clk_sys);
        pclk_on <= 1'b1;
        repeat (30) @(negedge clk_sys);
        check(link_on_int_osc, 1'b1, "hold bit keeps internal");
        bus(1'b1, 8'h03, 8'h00);
        wait_oni(1'b0);
        rd_chk(8'h20, 32'h06, "status on pixel clock");
        @(posedge clk_sys);
        pclk_on <= 1'b0;
        wait_oni(1'b1);
        $display("test clock switch done");
        @(posedge clk_sys);
        st_pins <= 2'b01;
        st_en <= 1'b1;
        repeat (4) @(negedge clk_sys);
        rd_chk(8'h14, 32'h02, "rate from back channel");
        rd_chk(8'h20, 32'h28, "status in self test");
        bus(1'b1, 8'h14, 8'h04);
        rd_chk(8'h14, 32'h02, "local rate write in test");
        repeat (8) begin
            prev_w = link_data;
            @(negedge clk_sys);
            check(link_data !== prev_w && link_data !== video_in, 1, "test pattern");
            check(st_pass, 1'b1, "far end pass level");
        end
        @(posedge clk_sys);
        st_en <= 1'b0;
        repeat (3) @(negedge clk_sys);
        check(link_data, 14'h2155, "normal traffic back");
        check(st_pass, 1'b1, "final result pulse");
        check(st_err_cnt, 8'h00, "far end error count");
        @(posedge clk_sys);
        video_in <= 14'h0c00;
        repeat (3) @(negedge clk_sys);
        check(link_data, 14'h0000, "ten bit payload");
        bus(1'b1, 8'h22, 8'h01);
        repeat (3) @(negedge clk_sys);
        check(link_data, 14'h0c00, "twelve bit payload");
        $display("test self test done");
        complete_run();
    end
endmodule : ser_ref_clock_select_and_link_self_test_test
